// >>> rtl/psc_pkg.sv
package psc_pkg;
    // byte geometry
    localparam int PSC_BYTE_W = 8;
    localparam logic [2:0] PSC_CNT_RESET = 3'h0;
    localparam logic [2:0] PSC_CNT_PRESET = 3'h1;
    localparam logic [2:0] PSC_CNT_LAST = 3'h7;
    localparam logic [7:0] PSC_DATA_RESET = 8'h00;
    // buffering
    localparam int PSC_FIFO_DEPTH = 16;
    // clock rate and write clock limit
    localparam int PSC_CLK_HZ = 10000000;
    localparam int PSC_WCLK_MAX_HZ = 5250000;
endpackage

// >>> rtl/psc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module psc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // psc_fifo
`default_nettype wire

// >>> rtl/psc_top.sv
`timescale 1ns/1ps
`default_nettype none
module psc_top
    import psc_pkg::*;
#(
    parameter int BYTE_W = PSC_BYTE_W,
    parameter int FIFO_DEPTH = PSC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // parallel load side
    input wire logic [BYTE_W-1:0] parallel_in,
    input wire logic byte_load_strobe_n,
    output logic load_ready,
    // write clock, sampled as a level
    input wire logic write_clock,
    // control
    input wire logic enable_n,
    input wire logic test_in,
    input wire logic test_in_oe,
    // serial side, with output enables on all but counter_preset_n
    output logic serial_out,
    output logic serial_out_oe,
    output logic byte_done_flag,
    output logic byte_done_flag_oe,
    output logic shift_clock_inv,
    output logic shift_clock_inv_oe,
    output logic shift_clock_copy,
    output logic shift_clock_copy_oe,
    output logic counter_preset_n
);
    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [1:0] {
        PSC_FREE = 2'b00,
        PSC_FULL = 2'b01
    } psc_state_e;

    psc_state_e state_q;
    logic strobe_q;
    logic wclk_q;
    logic [BYTE_W-1:0] latch_q;
    logic [BYTE_W-1:0] shreg_q;
    logic [2:0] count_q;
    logic done_q;
    logic test_eff;
    logic preset;
    logic wclk_rise;
    logic wclk_fall;
    logic strobe_rise;
    logic strobe_fall;
    logic fifo_valid;
    logic [BYTE_W-1:0] fifo_data;
    logic fifo_pop;
    logic fifo_ready;
    logic done_rise;

    // ==========================================================
    // edge detection
    // ==========================================================
    function automatic logic rising(input logic now, input logic was);
        rising = now && !was;
    endfunction

    assign wclk_rise = rising(write_clock, wclk_q);
    assign wclk_fall = rising(wclk_q, write_clock);
    assign strobe_rise = rising(byte_load_strobe_n, strobe_q);
    assign strobe_fall = rising(strobe_q, byte_load_strobe_n);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wclk_q <= 1'b0;
            strobe_q <= 1'b1;
        end
        else
        begin
            wclk_q <= write_clock;
            strobe_q <= byte_load_strobe_n;
        end
    end

    // ==========================================================
    // input buffering
    // ==========================================================
    // bytes stacked up here let a fast loader run ahead; a full
    // buffer drops load_ready so the loader holds its strobe
    psc_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(strobe_rise),
        .in_data(parallel_in),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            load_ready <= 1'b1;
        end
        else
        begin
            // one cycle late; a strobe on the fill cycle is dropped
            load_ready <= fifo_ready;
        end
    end

    // latch takes the oldest buffered byte once the shifter has
    // copied it; until then the byte waits in the buffer
    assign fifo_pop = fifo_valid && (state_q == PSC_FREE);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            latch_q <= PSC_DATA_RESET;
            state_q <= PSC_FREE;
        end
        else
        begin
            case (state_q)
                PSC_FREE:
                begin
                    if (fifo_pop)
                    begin
                        latch_q <= fifo_data;
                        state_q <= PSC_FULL;
                    end
                end
                PSC_FULL:
                begin
                    if (done_rise)
                    begin
                        state_q <= PSC_FREE;
                    end
                end
                default:
                begin
                    state_q <= PSC_FREE;
                end
            endcase
        end
    end

    // ==========================================================
    // byte counter and done flag
    // ==========================================================
    // open test input reads low, normal level
    assign test_eff = test_in_oe ? test_in : 1'b0;
    // wrap count decoded for both preset and flag
    function automatic logic at_last(input logic [2:0] cnt);
        at_last = (cnt == PSC_CNT_LAST);
    endfunction

    // preset is test or counter wrap
    assign preset = test_eff || at_last(count_q);
    assign done_rise = wclk_rise && at_last(count_q) && !test_eff;

    // modulo 8 count, free of enable
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_q <= PSC_CNT_RESET;
        end
        else if (wclk_rise)
        begin
            count_q <= test_eff ? PSC_CNT_PRESET : count_q + 3'h1;
        end
    end

    // set wins over clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
        end
        else if (done_rise)
        begin
            done_q <= 1'b1;
        end
        else if (strobe_fall)
        begin
            done_q <= 1'b0;
        end
    end

    // ==========================================================
    // shift register
    // ==========================================================
    // latency lands between 8 and 16 write clocks since the load
    // strobe has no phase tie to the counter
    // the serial pin takes the msb on the same fall, so each bit
    // stands one full write clock period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            shreg_q <= PSC_DATA_RESET;
        end
        else if (done_rise)
        begin
            shreg_q <= latch_q;
        end
        else if (wclk_fall)
        begin
            // msb first, one bit per fall
            shreg_q <= {shreg_q[BYTE_W-2:0], shreg_q[BYTE_W-1]};
        end
    end

    // ==========================================================
    // pin drivers
    // ==========================================================
    // bit leaves only on a fall
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            serial_out <= 1'b0;
        end
        else if (wclk_fall)
        begin
            serial_out <= shreg_q[BYTE_W-1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            byte_done_flag <= 1'b0;
            shift_clock_inv <= 1'b1;
            shift_clock_copy <= 1'b0;
            counter_preset_n <= 1'b1;
        end
        else
        begin
            byte_done_flag <= done_q;
            shift_clock_inv <= !write_clock;
            shift_clock_copy <= wclk_q;
            counter_preset_n <= !preset;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            serial_out_oe <= 1'b0;
            byte_done_flag_oe <= 1'b0;
            shift_clock_inv_oe <= 1'b0;
            shift_clock_copy_oe <= 1'b0;
        end
        else
        begin
            serial_out_oe <= !enable_n;
            byte_done_flag_oe <= !enable_n;
            shift_clock_inv_oe <= !enable_n;
            shift_clock_copy_oe <= !enable_n;
        end
    end
endmodule // psc_top
`default_nettype wire

// >>> tb/psc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// pin checks
module psc_checker (
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic byte_load_strobe_n,
    input wire logic write_clock,
    input wire logic enable_n,
    input wire logic test_in,
    input wire logic test_in_oe,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic byte_done_flag,
    input wire logic byte_done_flag_oe,
    input wire logic shift_clock_inv,
    input wire logic shift_clock_inv_oe,
    input wire logic shift_clock_copy,
    input wire logic shift_clock_copy_oe,
    input wire logic counter_preset_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_oe; 1 |=> {serial_out_oe, byte_done_flag_oe, shift_clock_inv_oe,
        shift_clock_copy_oe} == {4{!$past(enable_n)}};
    endproperty
    a_oe: assert property (p_oe) else $error("oe wrong");
    property p_clr; $fell(byte_load_strobe_n) |-> ##2 !byte_done_flag; endproperty
    a_clr: assert property (p_clr) else $error("flag kept");
    property p_hold; byte_done_flag && byte_load_strobe_n && $past(byte_load_strobe_n)
        |=> byte_done_flag; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    // hazard: a rise off the wclk edge means a miscount
    property p_rise; $rose(byte_done_flag) |-> $past(write_clock, 2)
        && !$past(write_clock, 4); endproperty
    a_rise: assert property (p_rise) else $error("flag early");
    property p_inv; $rose(write_clock) |-> ##[1:2] !shift_clock_inv; endproperty
    a_inv: assert property (p_inv) else $error("inv clock");
    property p_copy; $fell(write_clock) |-> ##[1:3] !shift_clock_copy; endproperty
    a_copy: assert property (p_copy) else $error("copy clock");
    property p_pre; (test_in && test_in_oe) [*3] |=> !counter_preset_n; endproperty
    a_pre: assert property (p_pre) else $error("no preset");
    property p_inh; (test_in && test_in_oe) [*6] |=> !$rose(byte_done_flag); endproperty
    a_inh: assert property (p_inh) else $error("count ran");
    property p_shift; !write_clock [*4] |=> $stable(serial_out); endproperty
    a_shift: assert property (p_shift) else $error("late shift");
    property p_edge; $changed(serial_out) |-> !$past(write_clock)
        && $past(write_clock, 2); endproperty
    a_edge: assert property (p_edge) else $error("dout off edge");
endmodule // psc_checker
bind psc_top psc_checker u_chk (.clk, .rst_n, .byte_load_strobe_n, .write_clock,
    .enable_n, .test_in, .test_in_oe, .serial_out, .serial_out_oe, .byte_done_flag,
    .byte_done_flag_oe, .shift_clock_inv, .shift_clock_inv_oe, .shift_clock_copy,
    .shift_clock_copy_oe, .counter_preset_n);
`default_nettype wire

// >>> tb/psc_loader.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host byte loader
module psc_loader (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // handshake
    input wire logic byte_done_flag,
    input wire logic stall,
    output logic [7:0] parallel_in,
    output logic byte_load_strobe_n,
    output int sent
);
    logic [7:0] tbl [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h96};
    task automatic load(input logic [7:0] b);
        @(negedge clk);
        parallel_in = b;
        byte_load_strobe_n = 1'b0;
        repeat (2) @(negedge clk);
        byte_load_strobe_n = 1'b1;
        repeat (2) @(negedge clk);
        parallel_in = ~b;
    endtask
    initial
    begin
        parallel_in = 8'h00;
        byte_load_strobe_n = 1'b1;
        sent = 0;
        wait (rst_n);
        load(8'h00);
        forever
        begin
            wait (byte_done_flag && !stall);
            // lag up to 40 clk, still inside the byte
            repeat (sent % 3 * 20) @(negedge clk);
            load(tbl[sent % 4]);
            sent++;
        end
    end
endmodule // psc_loader
`default_nettype wire

// >>> tb/psc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module psc_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic write_clock = 1'b0;
    logic enable_n = 1'b0;
    logic test_in = 1'b1;
    logic test_in_oe = 1'b0;
    logic stall = 1'b0;
    logic [7:0] parallel_in, x;
    logic byte_load_strobe_n, serial_out, byte_done_flag, counter_preset_n;
    wire logic [1:0] oe;
    logic load_ready;
    logic [63:0] hist = 64'h0;
    int sent, s, error_cnt = 0, check_count = 0;
    psc_top DUT (.clk, .rst_n, .parallel_in, .byte_load_strobe_n, .load_ready,
        .write_clock, .enable_n, .test_in, .test_in_oe, .serial_out,
        .serial_out_oe(oe[0]), .byte_done_flag, .byte_done_flag_oe(oe[1]),
        .shift_clock_inv(), .shift_clock_inv_oe(), .shift_clock_copy(),
        .shift_clock_copy_oe(), .counter_preset_n);
    psc_loader u_ld (.clk, .rst_n, .byte_done_flag, .stall, .parallel_in,
        .byte_load_strobe_n, .sent);
    initial forever #50 clk = ~clk;
    // wclk at clk/8, bit taken before each rise
    initial forever
    begin
        repeat (4) @(negedge clk);
        if (!write_clock)
            hist = {hist[62:0], serial_out};
        write_clock = ~write_clock;
    end
    task automatic ck(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // newest serial bit in bit 0, alignment free
    task automatic seek(input logic [63:0] p, input int n);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 900 && !ok; i++)
        begin
            @(negedge clk);
            ok = (((hist ^ p) & ((64'h1 << n) - 64'h1)) === 64'h0);
        end
        ck(ok, "bits missing");
        if (!ok)
            complete_run();
    endtask
    task automatic t_flow;
        seek(64'h00a53c0f96, 40);
        s = sent;
        enable_n = 1'b1;
        repeat (3) @(negedge clk);
        ck(oe === 2'h0, "driven");
        repeat (200) @(negedge clk);
        enable_n = 1'b0;
        repeat (3) @(negedge clk);
        ck(oe === 2'h3, "floating");
        ck(sent > s, "halted");
        ck(load_ready === 1'b1, "buffer full");
        seek(64'h3c0f96a5, 32);
        $display("flow done");
    endtask
    task automatic t_repeat;
        stall = 1'b1;
        repeat (60) @(negedge clk);
        x = u_ld.tbl[(sent + 3) % 4];
        seek({40'h0, x, x, x}, 24);
        stall = 1'b0;
        $display("repeat done");
    endtask
    task automatic t_inhibit;
        test_in_oe = 1'b1;
        repeat (80) @(negedge clk);
        stall = 1'b1;
        repeat (160) @(negedge clk);
        ck(counter_preset_n === 1'b0, "preset high");
        ck(byte_done_flag === 1'b0, "count ran");
        test_in_oe = 1'b0;
        for (int i = 0; i < 200 && byte_done_flag !== 1'b1; i++)
            @(negedge clk);
        ck(byte_done_flag === 1'b1, "count stuck");
        stall = 1'b0;
        $display("inhibit done");
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_flow();
        t_repeat();
        t_inhibit();
        complete_run();
    end
endmodule // psc_top_test
`default_nettype wire
